//--- hdl/conv_sync_map.svh
// reset values, widths and timing counts of the restart/reset control
// assumes a 20 MHz master clock; included by bare name
`ifndef CONV_SYNC_MAP_SVH
`define CONV_SYNC_MAP_SVH

// master clock period in ns
`define MCLK_PERIOD_NS   50
// master clocks per modulator cycle
`define MOD_CLKS         128
// modulator cycles per output update
`define UPDATE_MODS      16
// output-update periods of filter settling
`define SETTLE_UPDATES   3
// high time of result-ready on a pending-word update, in ns
`define BLINK_TIME_NS    25000
// the same time in master clocks
`define BLINK_CLKS       (`BLINK_TIME_NS / `MCLK_PERIOD_NS)
// setup register default
`define CFG_DEFAULT      16'h0100
// field widths
`define CFG_W            16
`define WORD_W           24

`endif

//--- hdl/conv_sync_pkg.sv
// types shared by the restart/reset control and its neighbours
// assumes conv_sync_map.svh supplies the widths
`include "conv_sync_map.svh"

package conv_sync_pkg;

  // result-ready states, gray along idle -> pending -> blink
  typedef enum logic [1:0] {
    RDY_IDLE  = 2'b00,
    RDY_PEND  = 2'b01,
    RDY_BLINK = 2'b11
  } rdy_state_t;

  // setup write from the serial port logic
  typedef struct packed {
    logic                  wr;
    logic [`CFG_W-1:0]     data;
  } cfg_wr_t;

  // steering of modulator and filter
  typedef struct packed {
    logic run;
    logic clear;
    logic mod_tick;
    logic update_tick;
  } core_ctrl_t;

endpackage

//--- hdl/conversion_sync_reset_control.sv
// restart, settling and hard-reset control of a sigma-delta converter
// assumes the serial port logic and the filter share clk; the restart
// and reset pins arrive asynchronously from the host
`timescale 1ns/1ps
`include "conv_sync_map.svh"

module conversion_sync_reset_control (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // host pins, asynchronous
  input  wire logic                    restart_pin_n,
  input  wire logic                    reset_pin_n,
  // serial port side, same clock
  input  wire logic                    filter_restart_bit,
  input  wire conv_sync_pkg::cfg_wr_t  cfg_in,
  input  wire logic                    data_rd,
  // filter result
  input  wire logic [`WORD_W-1:0]      filt_word,
  // modulator and filter steering
  output conv_sync_pkg::core_ctrl_t    core_ctrl,
  // register contents
  output logic [`CFG_W-1:0]            cfg_out,
  output logic [`WORD_W-1:0]           data_out,
  // pins
  output logic                         result_ready_n,
  output logic                         mclk_out
);
  import conv_sync_pkg::*;

  //////////////////////////////////////////////////////////////////
  // counter widths
  localparam int MOD_W   = $clog2(`MOD_CLKS);
  localparam int UPD_W   = $clog2(`UPDATE_MODS);
  localparam int BLINK_W = $clog2(`BLINK_CLKS + 1);

  // last values of each counter
  localparam logic [MOD_W-1:0]   MOD_LAST   = MOD_W'(`MOD_CLKS - 1);
  localparam logic [UPD_W-1:0]   UPD_LAST   = UPD_W'(`UPDATE_MODS - 1);
  localparam logic [1:0]         SETTLE_END = 2'(`SETTLE_UPDATES);
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(`BLINK_CLKS - 1);

  // wrap counter step, shared by the rate dividers
  function automatic logic [7:0] wrap_inc(input logic [7:0] cnt,
                                          input logic [7:0] last);
    logic [7:0] res;
    res = (cnt == last) ? 8'h00 : cnt + 8'h01;
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic restart_s1_reg;
  logic restart_s2_reg;
  logic reset_s1_reg;
  logic reset_s2_reg;

  // two flops per pin, idle high after reset
  // only the second flop of each pair is read by any logic
  always_ff @(posedge clk) begin
    if (srst) begin
      restart_s1_reg <= 1'b1;
      restart_s2_reg <= 1'b1;
      reset_s1_reg   <= 1'b1;
      reset_s2_reg   <= 1'b1;
    end else begin
      restart_s1_reg <= restart_pin_n;
      restart_s2_reg <= restart_s1_reg;
      reset_s1_reg   <= reset_pin_n;
      reset_s2_reg   <= reset_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////
  // reset and restart conditions
  logic hard_rst;
  logic restart;
  logic restart_dly_reg;
  logic restart_rise;

  // srst high or reset pin low resets everything past the synchronisers
  assign hard_rst = srst | ~reset_s2_reg;
  // effective restart: pin low or bit set
  // the bit comes from the serial port on clk and needs no synchroniser
  assign restart = ~restart_s2_reg | filter_restart_bit;
  // entry edge of the combined restart; release needs no edge, the
  // counters start on the first clock that sees restart low
  assign restart_rise = restart & ~restart_dly_reg;

  // previous restart level for edge detection
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      restart_dly_reg <= 1'b0;
    end else begin
      restart_dly_reg <= restart;
    end
  end

  //////////////////////////////////////////////////////////////////
  // rate dividers and settling count
  logic [MOD_W-1:0] mod_cnt_reg;
  logic [MOD_W-1:0] mod_cnt_next;
  logic [UPD_W-1:0] upd_cnt_reg;
  logic [UPD_W-1:0] upd_cnt_next;
  logic [1:0]       settle_reg;
  logic [1:0]       settle_next;
  logic             mod_tick;
  logic             upd_tick;
  logic             load;

  // one-cycle enables from the master clock
  // ticks fire on the last count, so every update lands on a wrap
  assign mod_tick = ~restart & (mod_cnt_reg == MOD_LAST);
  assign upd_tick = mod_tick & (upd_cnt_reg == UPD_LAST);
  // a word loads only once the filter has settled
  assign load = upd_tick & (settle_next == SETTLE_END);

  // next counts; restart clears them, which lines up devices
  always_comb begin
    mod_cnt_next = mod_cnt_reg;
    upd_cnt_next = upd_cnt_reg;
    settle_next  = settle_reg;
    if (restart) begin
      mod_cnt_next = '0;
      upd_cnt_next = '0;
      settle_next  = 2'h0;
    end else begin
      mod_cnt_next = MOD_W'(wrap_inc(8'(mod_cnt_reg), 8'(MOD_LAST)));
      if (mod_tick) begin
        upd_cnt_next = UPD_W'(wrap_inc(8'(upd_cnt_reg), 8'(UPD_LAST)));
      end
      if (upd_tick && settle_reg != SETTLE_END) begin
        settle_next = settle_reg + 2'h1;
      end
    end
  end

  // counter registers; hard reset restarts settling too
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      mod_cnt_reg <= '0;
      upd_cnt_reg <= '0;
      settle_reg  <= 2'h0;
    end else begin
      mod_cnt_reg <= mod_cnt_next;
      upd_cnt_reg <= upd_cnt_next;
      settle_reg  <= settle_next;
    end
  end

  //////////////////////////////////////////////////////////////////
  // setup and data registers
  logic [`CFG_W-1:0]  cfg_reg;
  logic [`CFG_W-1:0]  cfg_next;
  logic [`WORD_W-1:0] data_reg;
  logic [`WORD_W-1:0] data_next;

  // setup follows writes only; restart leaves it alone
  always_comb begin
    cfg_next  = cfg_reg;
    data_next = data_reg;
    if (cfg_in.wr) begin
      cfg_next = cfg_in.data;
    end
    if (load) begin
      data_next = filt_word;
    end
  end

  // hard reset returns defaults and blocks accesses
  // a setup write during hard reset is lost to the reset branch
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      cfg_reg  <= `CFG_DEFAULT;
      data_reg <= '0;
    end else begin
      cfg_reg  <= cfg_next;
      data_reg <= data_next;
    end
  end

  //////////////////////////////////////////////////////////////////
  // result-ready sequencing
  rdy_state_t         rdy_reg;
  rdy_state_t         rdy_next;
  logic [BLINK_W-1:0] blink_reg;
  logic [BLINK_W-1:0] blink_next;
  logic               rdy_n_reg;
  logic               rdy_n_next;
  logic               rd_ok;

  // reads count only outside hard reset
  assign rd_ok = data_rd & ~hard_rst;

  // restart never touches the state; a load, a read or the end of the blink count moves it
  // a read that meets a load in pending leaves ready high; the word lands
  always_comb begin
    rdy_next   = rdy_reg;
    blink_next = blink_reg;
    unique case (rdy_reg)
      RDY_IDLE: begin
        // high until settled and a word is present
        if (load) begin
          rdy_next = RDY_PEND;
        end
      end
      RDY_PEND: begin
        if (rd_ok) begin
          rdy_next = RDY_IDLE;
        end else if (load) begin
          rdy_next   = RDY_BLINK;
          blink_next = '0;
        end
        // restart release leaves a pending word low
      end
      RDY_BLINK: begin
        // high for BLINK_LAST + 1 clocks, counted from zero
        if (rd_ok) begin
          rdy_next = RDY_IDLE;
        end else if (blink_reg == BLINK_LAST) begin
          rdy_next = RDY_PEND;
        end else begin
          blink_next = blink_reg + BLINK_W'(1);
        end
      end
      default: begin
        rdy_next = RDY_IDLE;
      end
    endcase
    rdy_n_next = (rdy_next != RDY_PEND);
  end

  // ready state registers, high in hard reset
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      rdy_reg   <= RDY_IDLE;
      blink_reg <= '0;
      rdy_n_reg <= 1'b1;
    end else begin
      rdy_reg   <= rdy_next;
      blink_reg <= blink_next;
      rdy_n_reg <= rdy_n_next;
    end
  end

  //////////////////////////////////////////////////////////////////
  // steering of modulator and filter
  logic clear_reg;
  logic clear_next;

  // clear pulse on entry to restart or on hard reset
  // the pulse keeps clear up one cycle past a one-cycle restart
  always_comb begin
    clear_next = restart_rise;
  end

  // clear register, asserted through hard reset
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      clear_reg <= 1'b1;
    end else begin
      clear_reg <= clear_next;
    end
  end

  // run is held off while restart stands
  // hard reset forces run and both ticks low at once
  assign core_ctrl.run         = ~restart & ~hard_rst;
  assign core_ctrl.clear       = clear_reg | restart;
  assign core_ctrl.mod_tick    = mod_tick & ~hard_rst;
  assign core_ctrl.update_tick = load & ~hard_rst;

  // register contents and pins
  assign cfg_out        = cfg_reg;
  assign data_out       = data_reg;
  assign result_ready_n = rdy_n_reg;
  // the master clock passes straight out, reset or not
  // so a system clocked from this pin keeps running through reset
  assign mclk_out       = clk;

endmodule

//--- bench/conv_sync_monitor.sv
// checker of the restart/reset control, bound to its top module
// assumes the package and map header are compiled first
`timescale 1ns/1ps
`include "conv_sync_map.svh"

module conv_sync_monitor (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   srst,
  // inputs of the block
  input wire logic                   restart_pin_n,
  input wire logic                   reset_pin_n,
  input wire logic                   filter_restart_bit,
  input wire conv_sync_pkg::cfg_wr_t cfg_in,
  input wire logic                   data_rd,
  input wire logic [`WORD_W-1:0]     filt_word,
  // outputs of the block
  input wire conv_sync_pkg::core_ctrl_t core_ctrl,
  input wire logic [`CFG_W-1:0]      cfg_out,
  input wire logic [`WORD_W-1:0]     data_out,
  input wire logic                   result_ready_n,
  input wire logic                   mclk_out
);
  import conv_sync_pkg::*;
  logic [15:0] settle_reg, settle_next, cnt_reg, cnt_next;
  logic        blink_reg, blink_next;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // clocks since clear, and high time of a pending-word blink
  always_comb begin
    settle_next = core_ctrl.clear ? 16'h0000 : settle_reg + {15'h0000, ~&settle_reg};
    blink_next  = (blink_reg && !data_rd && !core_ctrl.clear
                   && !(!result_ready_n && cnt_reg != 16'h0000))
                  || (!result_ready_n && core_ctrl.update_tick && !data_rd);
    cnt_next    = !blink_reg ? 16'h0000 : cnt_reg + {15'h0000, result_ready_n};
  end
  always_ff @(posedge clk) begin
    settle_reg <= srst ? 16'h0000 : settle_next;
    blink_reg  <= srst ? 1'b0 : blink_next;
    cnt_reg    <= srst ? 16'h0000 : cnt_next;
  end

  sequence s_blink_end;
    blink_reg && !result_ready_n && cnt_reg != 16'h0000;
  endsequence

  a_read_sets_ready: assert property (data_rd && !core_ctrl.update_tick |=> result_ready_n)
    else $error("ready not high after a read");
  a_setup_write: assert property (cfg_in.wr && reset_pin_n && $past(reset_pin_n)
    && $past(reset_pin_n, 2) |=> cfg_out == $past(cfg_in.data))
    else $error("setup write not taken");
  a_hard_reset: assert property (!$past(reset_pin_n, 3) && !$past(reset_pin_n, 4)
    |-> result_ready_n && cfg_out == `CFG_DEFAULT && data_out == '0)
    else $error("hard reset state wrong");
  a_clock_output: assert property (@(negedge clk) disable iff (1'b0) mclk_out)
    else $error("clock output not following clock");
  a_clock_low: assert property (@(posedge clk) disable iff (1'b0) !mclk_out)
    else $error("clock output not low before a rising edge");
  a_restart_hold: assert property (filter_restart_bit && $past(filter_restart_bit)
    |-> core_ctrl.clear && !core_ctrl.run && !core_ctrl.update_tick)
    else $error("restart state not held");
  a_settle_wait: assert property (core_ctrl.update_tick |-> settle_reg >= 16'h17FE)
    else $error("word loaded before settling");
  a_mod_period: assert property (core_ctrl.mod_tick && core_ctrl.run
    |-> ##128 (core_ctrl.mod_tick || !core_ctrl.run))
    else $error("modulator cycle not 128 clocks");
  a_blink_length: assert property (s_blink_end |-> cnt_reg == 16'h01F4)
    else $error("pending blink not 500 clocks");
  a_pending_low: assert property (!result_ready_n && !data_rd && !core_ctrl.update_tick
    && reset_pin_n && $past(reset_pin_n) && $past(reset_pin_n, 2) |=> !result_ready_n)
    else $error("ready rose without cause");
  a_fall_on_load: assert property ($fell(result_ready_n) && !blink_reg
    |-> $past(core_ctrl.update_tick))
    else $error("ready fell without a load");
endmodule

bind conversion_sync_reset_control conv_sync_monitor mon (.clk(clk), .srst(srst),
  .restart_pin_n(restart_pin_n), .reset_pin_n(reset_pin_n),
  .filter_restart_bit(filter_restart_bit), .cfg_in(cfg_in), .data_rd(data_rd),
  .filt_word(filt_word), .core_ctrl(core_ctrl), .cfg_out(cfg_out), .data_out(data_out),
  .result_ready_n(result_ready_n), .mclk_out(mclk_out));

//--- bench/conv_host_model.sv
// host that drives the restart and hard-reset pins
// assumes requests come from the bench; pins move on falling edges
`timescale 1ns/1ps

module conv_host_model (
  // clock
  input  wire logic clk,
  // requests from the bench
  input  wire logic restart_req,
  input  wire logic reset_req,
  // pins toward the device
  output logic      restart_pin_n,
  output logic      reset_pin_n
);
  // requests taken on the rising edge, so the pins never race the bench
  logic restart_q = 1'b0;
  logic reset_q   = 1'b0;
  always @(posedge clk) begin
    restart_q <= restart_req;
    reset_q   <= reset_req;
  end
  // idle pins high; bench only restarts after setup, never in calibration
  initial begin
    restart_pin_n = 1'b1;
    reset_pin_n   = 1'b1;
  end
  always @(negedge clk) begin
    restart_pin_n <= !restart_q;
    reset_pin_n   <= !reset_q;
  end
endmodule

//--- bench/test_conversion_sync_reset_control.sv
// self-checking bench of the restart/reset control
// assumes the host model drives the pins; clock 20 MHz
`timescale 1ns/1ps
`include "conv_sync_map.svh"

module test_conversion_sync_reset_control;
  import conv_sync_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, bit_r = 1'b0, rd = 1'b0;
  logic        rs_req = 1'b0, rh_req = 1'b0, rs_n, rh_n, rdy_n, mclk;
  cfg_wr_t     cfg = '0;
  core_ctrl_t  cc;
  logic [15:0] cfg_out, setup;
  logic [23:0] word = 24'h000000, data_out;
  logic [23:0] exp_q[$];
  int          err_count = 0, checks_done = 0, seed = 67653, n;
  // clocks from release to the first word; pin lag is host capture plus two flops
  localparam int SETTLE_CLKS = `SETTLE_UPDATES * `UPDATE_MODS * `MOD_CLKS;
  localparam int PIN_LAG     = 3;

  always #25 clk = ~clk;

  conv_host_model host (.clk(clk), .restart_req(rs_req), .reset_req(rh_req),
    .restart_pin_n(rs_n), .reset_pin_n(rh_n));
  conversion_sync_reset_control dut (.clk(clk), .srst(srst), .restart_pin_n(rs_n),
    .reset_pin_n(rh_n), .filter_restart_bit(bit_r), .cfg_in(cfg), .data_rd(rd),
    .filt_word(word), .core_ctrl(cc), .cfg_out(cfg_out), .data_out(data_out),
    .result_ready_n(rdy_n), .mclk_out(mclk));

  // tallies one comparison and prints a difference
  task automatic tally(input logic same, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (!same) begin
      err_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // one compare task for each kind of result
  task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
    tally(got === exp, {8'h00, got}, {8'h00, exp});
  endtask
  task automatic cmp_cfg(input logic [15:0] got, input logic [15:0] exp);
    tally(got === exp, {16'h0000, got}, {16'h0000, exp});
  endtask
  task automatic cmp_rdy(input logic got, input logic exp);
    tally(got === exp, {31'h00000000, got}, {31'h00000000, exp});
  endtask
  task automatic cmp_count(input int got, input int exp);
    tally(got == exp, 32'(got), 32'(exp));
  endtask

  task automatic print_verdict;
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // bounded wait for ready to reach a level, clocks counted in n
  task automatic wait_rdy(input logic lvl);
    n = 0;
    while (rdy_n !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 8000) begin
        err_count++;
        print_verdict;
      end
    end
  endtask

  // restart by pin or bit for 200 clocks, then note the next word
  task automatic restart(input logic by_pin);
    if (by_pin) rs_req = 1'b1;
    else bit_r = 1'b1;
    repeat (200) @(negedge clk);
    word = 24'($random(seed));
    exp_q.push_back(word);
    rs_req = 1'b0;
    bit_r = 1'b0;
  endtask

  // each fall of ready is held against the oldest noted word
  always @(negedge rdy_n) begin
    #1;
    if (exp_q.size() > 0) cmp_word(data_out, exp_q.pop_front());
    else tally(1'b0, {8'h00, data_out}, 32'hFFFFFFFF);
  end

  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    cmp_rdy(rdy_n, 1'b1);
    setup = 16'($random(seed));
    cfg = '{1'b1, setup};
    @(negedge clk);
    cfg.wr = 1'b0;
    cmp_cfg(cfg_out, setup);
    restart(1'b1);
    cmp_cfg(cfg_out, setup);
    wait_rdy(1'b0);
    cmp_count(n, SETTLE_CLKS + PIN_LAG);
    restart(1'b0);
    repeat (3) @(negedge clk);
    cmp_rdy(rdy_n, 1'b0);
    wait_rdy(1'b1);
    cmp_count(n, SETTLE_CLKS - 3);
    n = 0;
    while (rdy_n === 1'b1 && n < 1000) begin
      n++;
      @(negedge clk);
    end
    cmp_count(n, `BLINK_CLKS);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    cmp_rdy(rdy_n, 1'b1);
    restart(1'b0);
    wait_rdy(1'b0);
    cmp_count(n, SETTLE_CLKS);
    rh_req = 1'b1;
    repeat (5) @(negedge clk);
    cfg = '{1'b1, ~setup};
    @(negedge clk);
    cfg.wr = 1'b0;
    repeat (4) @(negedge clk);
    cmp_rdy(rdy_n, 1'b1);
    cmp_cfg(cfg_out, `CFG_DEFAULT);
    cmp_word(data_out, 24'h000000);
    repeat (190) @(negedge clk);
    word = 24'($random(seed));
    exp_q.push_back(word);
    rh_req = 1'b0;
    wait_rdy(1'b0);
    cmp_count(n, SETTLE_CLKS + PIN_LAG);
    cmp_cfg(cfg_out, `CFG_DEFAULT);
    cfg = '{1'b1, setup};
    @(negedge clk);
    cfg.wr = 1'b0;
    cmp_cfg(cfg_out, setup);
    cmp_count(exp_q.size(), 0);
    print_verdict;
  end
endmodule
